/* rtl/sssp_pkg.sv */
package sssp_pkg;

    // -------------------------------------------------------------------------
    // register byte addresses
    // -------------------------------------------------------------------------
    localparam logic [3:0] SSSP_ADDR_BAUD   = 4'h0;
    localparam logic [3:0] SSSP_ADDR_RXDATA = 4'h1;
    localparam logic [3:0] SSSP_ADDR_RXSTA  = 4'h2;
    localparam logic [3:0] SSSP_ADDR_TRANSMIT_STATUS_CONTROL  = 4'h3;
    localparam logic [3:0] SSSP_ADDR_TXDATA = 4'h4;
    localparam logic [3:0] SSSP_ADDR_IRQST  = 4'h5;
    localparam logic [3:0] SSSP_ADDR_IRQMSK = 4'h6;
    localparam logic [3:0] SSSP_ADDR_CORE   = 4'h7;

    // -------------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------------
    localparam int SSSP_BAUD_POL     = 4;
    localparam int SSSP_BAUD_IDLE    = 6;
    localparam int SSSP_RX_PEN       = 7;
    localparam int SSSP_RX_NINE      = 6;
    localparam int SSSP_RX_SINGLE    = 5;
    localparam int SSSP_RX_CONT      = 4;
    localparam int SSSP_RX_OVR       = 1;
    localparam int SSSP_RX_BIT9      = 0;
    localparam int SSSP_TX_CLOCK_SOURCE_MASTER_SELECT      = 7;
    localparam int SSSP_TX_NINE      = 6;
    localparam int SSSP_TX_EN        = 5;
    localparam int SSSP_TX_SYNC      = 4;
    localparam int SSSP_TX_EMPTY     = 1;
    localparam int SSSP_TX_BIT9      = 0;
    localparam int SSSP_IRQ_RX       = 0;
    localparam int SSSP_IRQ_TX       = 1;
    localparam int SSSP_IRQ_OVR      = 2;
    localparam int SSSP_CORE_SLEEP   = 0;
    localparam int SSSP_CORE_GIE     = 1;
    localparam int SSSP_CORE_PERIPHERAL_IRQ_ENABLE    = 2;

    // -------------------------------------------------------------------------
    // reset values and sizes
    // -------------------------------------------------------------------------
    localparam logic [7:0] SSSP_RST_BYTE  = 8'h00;
    localparam logic [15:0] SSSP_VECTOR   = 16'h0004;
    localparam int SSSP_FIFO_DEPTH        = 2;
    localparam int SSSP_BITS_NINE         = 9;
    localparam int SSSP_BITS_EIGHT        = 8;

    // received character carried with its ninth bit
    typedef struct packed {
        logic       bit9;
        logic [7:0] data;
    } sssp_char_t;

endpackage

/* rtl/sssp_top.sv */
`timescale 1ns/10ps
`default_nettype none
module sssp_top
    import sssp_pkg::*;
#(
    parameter int DEPTH = SSSP_FIFO_DEPTH
) (
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    input  wire logic [3:0] AVS_ADDRESS_I,
    input  wire logic       AVS_READ_I,
    input  wire logic       AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0]     AVS_READDATA_O,
    output logic            AVS_WAITREQUEST_O,
    input  wire logic       SER_CLK_I,
    input  wire logic       SER_DATA_I,
    output logic            SER_DATA_O,
    output logic            SER_DATA_OE_N_O,
    output logic            IRQ_O,
    output logic            WAKE_O,
    output logic            VECTOR_O
);

    // -------------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------------
    logic [7:0] baud_r, rxsta_r, transmit_status_control_r, irq_st_r, irq_msk_r, core_r;
    logic       ack_r;
    logic [1:0] clk_sync_r, dat_sync_r;
    logic       clk_prev_r;
    sssp_char_t fifo_r [DEPTH];
    logic [$clog2(DEPTH):0] cnt_r;
    logic [$clog2(DEPTH)-1:0] rd_ptr_r, wr_ptr_r;
    logic [8:0] rsr_r;
    logic [3:0] rx_bits_r;
    logic       ovr_r;
    logic [8:0] tsr_r;
    logic [3:0] tx_bits_r;
    logic       tsr_full_r;
    logic [8:0] thr_r;
    logic       thr_full_r;
    logic       vec_r;

    // -------------------------------------------------------------------------
    // mode decode
    // -------------------------------------------------------------------------
    logic port_on, slave, rx_mode, tx_mode, edge_take, rx_done, tx_done;
    logic bus_req, rd_pop, tx_wr;
    logic [3:0] nbits, tx_nbits;

    assign port_on = rxsta_r[SSSP_RX_PEN];
    assign slave   = port_on & transmit_status_control_r[SSSP_TX_SYNC] & ~transmit_status_control_r[SSSP_TX_CLOCK_SOURCE_MASTER_SELECT];
    // single receive bit is not looked at for slave receive; it only blocks slave transmit
    assign rx_mode = slave & rxsta_r[SSSP_RX_CONT];
    assign tx_mode = slave & ~rxsta_r[SSSP_RX_CONT] & ~rxsta_r[SSSP_RX_SINGLE] & transmit_status_control_r[SSSP_TX_EN];
    assign nbits   = rxsta_r[SSSP_RX_NINE] ? 4'(SSSP_BITS_NINE) : 4'(SSSP_BITS_EIGHT);
    // transmit length follows its own nine-bit select, not the receiver's
    assign tx_nbits = transmit_status_control_r[SSSP_TX_NINE] ? 4'(SSSP_BITS_NINE) : 4'(SSSP_BITS_EIGHT);

    // -------------------------------------------------------------------------
    // link clock sampling
    // -------------------------------------------------------------------------
    // shifting is paced solely by the master's clock, so it keeps running
    // while the core sleeps; the system clock only oversamples it
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            clk_sync_r <= 2'h0;
            dat_sync_r <= 2'h0;
            clk_prev_r <= 1'b0;
        end else begin
            clk_sync_r <= {clk_sync_r[0], SER_CLK_I};
            dat_sync_r <= {dat_sync_r[0], SER_DATA_I};
            clk_prev_r <= clk_sync_r[1];
        end
    end

    // polarity selects the sampling edge: rising by default, falling if set
    assign edge_take = slave & (baud_r[SSSP_BAUD_POL] ? (clk_prev_r & ~clk_sync_r[1])
                                                      : (~clk_prev_r & clk_sync_r[1]));

    // -------------------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------------------
    assign bus_req = (AVS_READ_I | AVS_WRITE_I) & ~ack_r;
    assign rd_pop  = bus_req & AVS_READ_I & (AVS_ADDRESS_I == SSSP_ADDR_RXDATA) & (cnt_r != '0);
    assign tx_wr   = bus_req & AVS_WRITE_I & (AVS_ADDRESS_I == SSSP_ADDR_TXDATA);

    // one wait state per access: answer lands the cycle after the request;
    // waitrequest is its own flop so the pin carries no decode glitches
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ack_r             <= 1'b0;
            AVS_WAITREQUEST_O <= 1'b1;
        end else begin
            ack_r             <= bus_req;
            AVS_WAITREQUEST_O <= ~bus_req;
        end
    end

    // -------------------------------------------------------------------------
    // receive shift and fifo
    // -------------------------------------------------------------------------
    assign rx_done = rx_mode & edge_take & (rx_bits_r == nbits - 4'h1);

    always_ff @(posedge CLK_I) begin
        if (RST_I | ~rx_mode) begin
            rsr_r     <= 9'h000;
            rx_bits_r <= 4'h0;
        end else if (edge_take) begin
            // lsb first: fill from the top, align on completion
            rsr_r     <= {dat_sync_r[1], rsr_r[8:1]};
            rx_bits_r <= rx_done ? 4'h0 : rx_bits_r + 4'h1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I | ~port_on) begin
            cnt_r    <= '0;
            rd_ptr_r <= '0;
            wr_ptr_r <= '0;
        end else begin
            if (rd_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (rx_done & (cnt_r != DEPTH[$clog2(DEPTH):0])) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            cnt_r <= cnt_r + (rx_done & (cnt_r != DEPTH[$clog2(DEPTH):0]) ? 1'b1 : 1'b0)
                           - (rd_pop ? 1'b1 : 1'b0);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            for (int i = 0; i < DEPTH; i++) begin
                fifo_r[i] <= '0;
            end
        end else if (rx_done & (cnt_r != DEPTH[$clog2(DEPTH):0])) begin
            if (rxsta_r[SSSP_RX_NINE]) begin
                fifo_r[wr_ptr_r] <= {dat_sync_r[1], rsr_r[8:1]};
            end else begin
                fifo_r[wr_ptr_r] <= {1'b0, dat_sync_r[1], rsr_r[8:2]};
            end
        end
    end

    // overrun: a character completes with the fifo full; the character is lost
    always_ff @(posedge CLK_I) begin
        if (RST_I | ~rx_mode) begin
            ovr_r <= 1'b0;
        end else if (rx_done & (cnt_r == DEPTH[$clog2(DEPTH):0])) begin
            ovr_r <= 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // transmit path
    // -------------------------------------------------------------------------
    // data changes on the edge opposite the master's sampling edge
    logic drive_edge;
    assign drive_edge = slave & (baud_r[SSSP_BAUD_POL] ? (~clk_prev_r & clk_sync_r[1])
                                                       : (clk_prev_r & ~clk_sync_r[1]));
    assign tx_done = tx_mode & tsr_full_r & drive_edge & (tx_bits_r == tx_nbits - 4'h1);

    always_ff @(posedge CLK_I) begin
        if (RST_I | ~port_on) begin
            tsr_r      <= 9'h000;
            tx_bits_r  <= 4'h0;
            tsr_full_r <= 1'b0;
            thr_r      <= 9'h000;
            thr_full_r <= 1'b0;
        end else begin
            if (tx_wr) begin
                thr_r      <= {transmit_status_control_r[SSSP_TX_BIT9], AVS_WRITEDATA_I[7:0]};
                thr_full_r <= 1'b1;
            end
            if ((~tsr_full_r | tx_done) & thr_full_r & ~tx_wr) begin
                // holding byte moves into the shift register, buffer frees
                tsr_r      <= thr_r;
                tsr_full_r <= 1'b1;
                tx_bits_r  <= 4'h0;
                thr_full_r <= 1'b0;
            end else if (tx_done) begin
                tsr_full_r <= 1'b0;
                tx_bits_r  <= 4'h0;
            end else if (tx_mode & tsr_full_r & drive_edge) begin
                tsr_r     <= {1'b0, tsr_r[8:1]};
                tx_bits_r <= tx_bits_r + 4'h1;
            end
        end
    end

    // pin driven, low-active enable, whenever slave transmit mode is on, with or without data to send
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            SER_DATA_O      <= 1'b1;
            SER_DATA_OE_N_O <= 1'b1;
        end else begin
            SER_DATA_O      <= tsr_full_r ? tsr_r[0] : 1'b1;
            SER_DATA_OE_N_O <= ~tx_mode;
        end
    end

    // -------------------------------------------------------------------------
    // events and interrupt
    // -------------------------------------------------------------------------
    logic rx_flag, tx_flag;
    logic [7:0] ev;
    assign rx_flag = (cnt_r != '0);
    assign tx_flag = ~thr_full_r;
    assign ev = {5'h00, rx_done & (cnt_r == DEPTH[$clog2(DEPTH):0]), tx_done, rx_done};

    // set beats a simultaneous write-one clear
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            irq_st_r <= SSSP_RST_BYTE;
        end else if (bus_req & AVS_WRITE_I & (AVS_ADDRESS_I == SSSP_ADDR_IRQST)) begin
            irq_st_r <= (irq_st_r & ~AVS_WRITEDATA_I[7:0]) | ev;
        end else begin
            irq_st_r <= irq_st_r | ev;
        end
    end

    // wake needs the level flags; transmit also needs peripheral enable
    logic wake_nxt, irq_nxt;
    assign wake_nxt = (rx_flag & irq_msk_r[SSSP_IRQ_RX])
                    | (tx_flag & irq_msk_r[SSSP_IRQ_TX] & core_r[SSSP_CORE_PERIPHERAL_IRQ_ENABLE]);
    assign irq_nxt  = |(irq_st_r & irq_msk_r);

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            IRQ_O    <= 1'b0;
            WAKE_O   <= 1'b0;
            VECTOR_O <= 1'b0;
            vec_r    <= 1'b0;
        end else begin
            IRQ_O    <= irq_nxt;
            WAKE_O   <= wake_nxt & core_r[SSSP_CORE_SLEEP];
            // on the wake condition, asleep or not, branch to the fixed vector only with global enable
            vec_r    <= wake_nxt & core_r[SSSP_CORE_GIE];
            VECTOR_O <= vec_r;
        end
    end

    // -------------------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            baud_r    <= SSSP_RST_BYTE;
            rxsta_r   <= SSSP_RST_BYTE;
            transmit_status_control_r   <= SSSP_RST_BYTE;
            irq_msk_r <= SSSP_RST_BYTE;
            core_r    <= SSSP_RST_BYTE;
        end else begin
            if (bus_req & AVS_WRITE_I) begin
                unique case (AVS_ADDRESS_I)
                    SSSP_ADDR_BAUD:   baud_r    <= AVS_WRITEDATA_I[7:0] & 8'h10;
                    SSSP_ADDR_RXSTA:  rxsta_r   <= AVS_WRITEDATA_I[7:0] & 8'hF0;
                    SSSP_ADDR_TRANSMIT_STATUS_CONTROL:  transmit_status_control_r   <= AVS_WRITEDATA_I[7:0] & 8'hF1;
                    SSSP_ADDR_IRQMSK: irq_msk_r <= AVS_WRITEDATA_I[7:0] & 8'h07;
                    SSSP_ADDR_CORE:   core_r    <= AVS_WRITEDATA_I[7:0] & 8'h07;
                    default: ;
                endcase
            end else if (core_r[SSSP_CORE_SLEEP] & wake_nxt) begin
                core_r[SSSP_CORE_SLEEP] <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------------
    // read data
    // -------------------------------------------------------------------------
    sssp_char_t head;
    assign head = fifo_r[rd_ptr_r];

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            AVS_READDATA_O <= 32'h0000_0000;
        end else if (bus_req & AVS_READ_I) begin
            unique case (AVS_ADDRESS_I)
                SSSP_ADDR_BAUD:   AVS_READDATA_O <= {24'h0, baud_r | {1'b0, ~rx_mode, 6'h00}};
                SSSP_ADDR_RXDATA: AVS_READDATA_O <= {24'h0, head.data};
                SSSP_ADDR_RXSTA:  AVS_READDATA_O <= {24'h0, rxsta_r[7:2], ovr_r, head.bit9};
                SSSP_ADDR_TRANSMIT_STATUS_CONTROL:  AVS_READDATA_O <= {24'h0, transmit_status_control_r[7:3], ~tsr_full_r, tx_flag, transmit_status_control_r[0]};
                SSSP_ADDR_IRQST:  AVS_READDATA_O <= {24'h0, irq_st_r};
                SSSP_ADDR_IRQMSK: AVS_READDATA_O <= {24'h0, irq_msk_r};
                SSSP_ADDR_CORE:   AVS_READDATA_O <= {24'h0, core_r[7:4], rx_flag, core_r[2:0]};
                default:          AVS_READDATA_O <= 32'h0000_0000;
            endcase
        end
    end

endmodule
`default_nettype wire

/* tb/sssp_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module sssp_chk
    import sssp_pkg::*;
(
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic        AVS_READ_I,
    input wire logic        AVS_WRITE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic        AVS_WAITREQUEST_O,
    input wire logic        SER_CLK_I,
    input wire logic        SER_DATA_O,
    input wire logic        SER_DATA_OE_N_O,
    input wire logic        IRQ_O,
    input wire logic        WAKE_O,
    input wire logic        VECTOR_O
);
    logic       clk_d_r;
    logic [3:0] quiet_r;

    // cycles since the link clock last moved; a wake must follow link traffic
    always_ff @(posedge CLK_I) begin
        clk_d_r <= SER_CLK_I;
        if (RST_I || SER_CLK_I != clk_d_r) begin
            quiet_r <= 4'h0;
        end else if (quiet_r != 4'hF) begin
            quiet_r <= quiet_r + 4'h1;
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    // ------------------------------------------------------------------
    // port relations
    // ------------------------------------------------------------------
    a_reset_idle: assert property ($fell(RST_I) |-> AVS_WAITREQUEST_O && SER_DATA_OE_N_O && !IRQ_O && !WAKE_O)
        else $error("outputs not idle after reset");
    a_wait_answer: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("request not answered after one wait state");
    a_wait_single: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low for more than one cycle");
    a_wait_cause: assert property ($fell(AVS_WAITREQUEST_O) |-> $past(AVS_READ_I) || $past(AVS_WRITE_I))
        else $error("answer without a request");
    a_rdata_hold: assert property (!AVS_READ_I |=> $stable(AVS_READDATA_O))
        else $error("read data moved without a read");
    // with polarity clear data moves after a falling link clock edge; it must never move deep in the high phase
    a_tx_step: assert property (SER_CLK_I [*4] |-> $stable(SER_DATA_O))
        else $error("transmit data moved while link clock high");
    a_vector_wake: assert property ($rose(VECTOR_O) |-> $past(WAKE_O) || $past(WAKE_O, 2))
        else $error("vector without a preceding wake");
    a_wake_link: assert property ($rose(WAKE_O) |-> quiet_r < 4'hA)
        else $error("wake without recent link clocks");

    c_wake: cover property ($rose(WAKE_O));
    c_vector: cover property ($rose(VECTOR_O));
    c_drive: cover property ($fell(SER_DATA_OE_N_O));
    c_irq: cover property ($rose(IRQ_O));
endmodule
`default_nettype wire

/* tb/sssp_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sssp_master_model (
    output logic      ser_clk_o,
    output logic      ser_data_o,
    input wire logic  ser_data_i
);
    // clock rests low between frames
    initial begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b1;
    end

    // one frame, 320 ns per bit, lsb first; data moves mid low phase so
    // both sampling edges find it settled; device bit taken late in the
    // high phase so the device's input synchroniser delay is tolerated
    task automatic xfer(input int n, input logic [8:0] tx, output logic [8:0] rx);
        rx = 9'h000;
        #13;
        for (int i = 0; i < n; i++) begin
            #80 ser_data_o = tx[i];
            #80 ser_clk_o = 1'b1;
            #150 rx[i] = ser_data_i;
            #10 ser_clk_o = 1'b0;
        end
        // last bit held past the final fall for falling-edge sampling
        #80;
        // released line shows the inverse, never a stale bit
        ser_data_o = ~ser_data_o;
    endtask
endmodule
`default_nettype wire

/* tb/test_sync_slave_serial_port.sv */
`timescale 1ns/10ps
`default_nettype none
module test_sync_slave_serial_port
    import sssp_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        rd = 1'b0, wr = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        waitreq, sdo, oe_n, irq, wake, vec, mclk, mdo;
    logic        saw_w = 1'b0, saw_v = 1'b0;
    logic [8:0]  got;
    int          bad_count = 0, compares = 0;
    wire logic   pin;

    always #20 clk_i = ~clk_i;
    // the device wins the shared data line while its enable is low
    assign pin = (oe_n === 1'b0) ? sdo : mdo;
    // wake and vector may be short; remember that they were seen
    always @(posedge clk_i) begin
        if (wake === 1'b1) saw_w <= 1'b1;
        if (vec === 1'b1) saw_v <= 1'b1;
    end

    sssp_top #(.DEPTH(2)) dut (
        .CLK_I(clk_i), .RST_I(rst_i), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
        .SER_CLK_I(mclk), .SER_DATA_I(pin), .SER_DATA_O(sdo),
        .SER_DATA_OE_N_O(oe_n), .IRQ_O(irq), .WAKE_O(wake), .VECTOR_O(vec)
    );
    sssp_master_model mst (.ser_clk_o(mclk), .ser_data_o(mdo), .ser_data_i(pin));

    // ------------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        if (bad_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // drive after an edge, hold until waitrequest is sampled low; the first
    // edge keeps a release and a new request out of one time step
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        addr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= {24'h0, d};
        @(posedge clk_i);
        while (waitreq !== 1'b0) @(posedge clk_i);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q & {24'h0, m}, {24'h0, e});
    endtask

    // a frame plus a short settle for the input synchroniser
    task automatic frame(input int n, input logic [8:0] tx);
        mst.xfer(n, tx, got);
        repeat (4) @(posedge clk_i);
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(4'h8, 8'hFF, 8'h00);
        wrr(4'h9, 8'hFF);
        rdc(SSSP_ADDR_IRQST, 8'h07, 8'h00);
        wrr(SSSP_ADDR_TRANSMIT_STATUS_CONTROL, 8'h10);
        wrr(SSSP_ADDR_RXSTA, 8'h90);
        wrr(SSSP_ADDR_IRQMSK, 8'h01);
        frame(8, 9'h0A5);
        rdc(SSSP_ADDR_CORE, 8'h08, 8'h08);
        chk({31'h0, irq}, 32'h1);
        rdc(SSSP_ADDR_RXDATA, 8'hFF, 8'hA5);
        rdc(SSSP_ADDR_CORE, 8'h08, 8'h00);
        wrr(SSSP_ADDR_IRQST, 8'h01);
        rdc(SSSP_ADDR_IRQST, 8'h01, 8'h00);
        chk({31'h0, irq}, 32'h0);
        // nine-bit pair back to back, interrupt masked
        wrr(SSSP_ADDR_IRQMSK, 8'h00);
        wrr(SSSP_ADDR_RXSTA, 8'hD0);
        frame(9, 9'h13C);
        frame(9, 9'h0C3);
        chk({31'h0, irq}, 32'h0);
        rdc(SSSP_ADDR_RXSTA, 8'h01, 8'h01);
        rdc(SSSP_ADDR_RXDATA, 8'hFF, 8'h3C);
        rdc(SSSP_ADDR_RXSTA, 8'h01, 8'h00);
        rdc(SSSP_ADDR_RXDATA, 8'hFF, 8'hC3);
        // single enable set as well; third character overruns the fifo
        wrr(SSSP_ADDR_RXSTA, 8'hB0);
        frame(8, 9'h011);
        frame(8, 9'h022);
        frame(8, 9'h033);
        rdc(SSSP_ADDR_RXSTA, 8'h02, 8'h02);
        rdc(SSSP_ADDR_RXDATA, 8'hFF, 8'h11);
        wrr(SSSP_ADDR_RXSTA, 8'hA0);
        rdc(SSSP_ADDR_RXSTA, 8'h02, 8'h00);
        rdc(SSSP_ADDR_RXDATA, 8'hFF, 8'h22);
        // receive while asleep with global enable
        wrr(SSSP_ADDR_RXSTA, 8'h90);
        wrr(SSSP_ADDR_IRQST, 8'h07);
        wrr(SSSP_ADDR_IRQMSK, 8'h01);
        wrr(SSSP_ADDR_CORE, 8'h07);
        frame(8, 9'h05C);
        rdc(SSSP_ADDR_CORE, 8'h01, 8'h00);
        chk({31'h0, saw_w}, 32'h1);
        chk({31'h0, saw_v}, 32'h1);
        rdc(SSSP_ADDR_RXDATA, 8'hFF, 8'h5C);
        // falling-edge sampling, awake and with global enable off
        wrr(SSSP_ADDR_CORE, 8'h00);
        wrr(SSSP_ADDR_BAUD, 8'h10);
        rdc(SSSP_ADDR_BAUD, 8'h50, 8'h10);
        frame(8, 9'h0E7);
        rdc(SSSP_ADDR_RXDATA, 8'hFF, 8'hE7);
        wrr(SSSP_ADDR_BAUD, 8'h00);
        // slave transmit with shift register and holding buffer both loaded
        wrr(SSSP_ADDR_CORE, 8'h04);
        wrr(SSSP_ADDR_RXSTA, 8'h80);
        wrr(SSSP_ADDR_TRANSMIT_STATUS_CONTROL, 8'h30);
        wrr(SSSP_ADDR_IRQST, 8'h07);
        wrr(SSSP_ADDR_TXDATA, 8'h5A);
        wrr(SSSP_ADDR_TXDATA, 8'h96);
        rdc(SSSP_ADDR_TRANSMIT_STATUS_CONTROL, 8'h02, 8'h00);
        chk({31'h0, oe_n}, 32'h0);
        frame(8, 9'h000);
        chk({23'h0, got}, 32'h5A);
        rdc(SSSP_ADDR_TRANSMIT_STATUS_CONTROL, 8'h02, 8'h02);
        rdc(SSSP_ADDR_IRQST, 8'h02, 8'h02);
        wrr(SSSP_ADDR_TXDATA, 8'h3C);
        rdc(SSSP_ADDR_TRANSMIT_STATUS_CONTROL, 8'h02, 8'h00);
        frame(8, 9'h1FF);
        chk({23'h0, got}, 32'h96);
        // transmit while asleep: emptying the holding buffer wakes the core
        wrr(SSSP_ADDR_TXDATA, 8'h81);
        wrr(SSSP_ADDR_IRQMSK, 8'h02);
        wrr(SSSP_ADDR_CORE, 8'h05);
        rdc(SSSP_ADDR_CORE, 8'h01, 8'h01);
        frame(8, 9'h000);
        chk({23'h0, got}, 32'h3C);
        rdc(SSSP_ADDR_CORE, 8'h01, 8'h00);
        stop_test();
    end

    // eleven frames and a few dozen bus cycles need far less than this
    initial begin
        #500000;
        bad_count++;
        stop_test();
    end
endmodule

bind sssp_top sssp_chk u_chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .AVS_READ_I(AVS_READ_I),
    .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .SER_CLK_I(SER_CLK_I),
    .SER_DATA_O(SER_DATA_O), .SER_DATA_OE_N_O(SER_DATA_OE_N_O),
    .IRQ_O(IRQ_O), .WAKE_O(WAKE_O), .VECTOR_O(VECTOR_O)
);
`default_nettype wire
